// file: logic/bsw_defs.svh
`ifndef BSW_DEFS_SVH
`define BSW_DEFS_SVH

// Register address in the processor's memory-mapped space
`define BSW_CTRL_ADDR      16'h0029
// Field positions
`define BSW_CMP_HI         15
`define BSW_CMP_LO         12
`define BSW_GAP_BIT        11
`define BSW_RSV_HI         10
`define BSW_RSV_LO         3
`define BSW_HPK_BIT        2
`define BSW_DBK_BIT        1
`define BSW_OFF_BIT        0
// Reset values
`define BSW_CMP_RST        4'hF
`define BSW_GAP_RST        1'b1
`define BSW_HPK_RST        1'b0
`define BSW_DBK_RST        1'b0
`define BSW_OFF_RST        1'b0

`endif

// file: logic/bsw_pkg.sv
package bsw_pkg;
  typedef enum logic [2:0] {
    BSW_IDLE  = 3'b001,
    BSW_GAP   = 3'b010,
    BSW_DRAIN = 3'b100
  } bsw_state_t;
endpackage

// file: logic/bsw_bank_switch.sv
// Summary of operation
// - Add one cycle when consecutive same-space external accesses change bank.
// - Add one cycle when a data access is followed by a program access.
// - Compare mask in bits 15-12 picks high address bits compared; resets ones.
// - Mask 1111 compares bits 15-12 giving 4K banks; sizes 4K to 64K.
// - Bit 11 set adds a cycle between program and data reads either order.
// - Bits 10-3 reserved, read zero, writes leave them unchanged.
// - Bit 2 enables host-port bus keeper, cleared at reset.
// - Bit 1 enables data bus keeper, holding undriven data bus at last level.
// - Bit 0 finishes current cycle then makes external bus inactive.
// - While bus is off, mode, overlay, data-ROM and hold-mode writes are blocked.
`include "bsw_defs.svh"

module bsw_bank_switch
  import bsw_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Memory-mapped register port
  input  wire logic [15:0]       mmr_addr_i,
  input  wire logic              mmr_wr_i,
  input  wire logic              mmr_rd_i,
  input  wire logic [15:0]       mmr_wdata_i,
  output logic      [15:0]       mmr_rdata_o,
  // Core external access request
  input  wire logic              acc_req_i,
  input  wire logic              acc_prog_i,
  input  wire logic              acc_read_i,
  input  wire logic [ADDR_W-1:0] acc_addr_i,
  output logic                   acc_stall_o,
  output logic                   acc_issue_o,
  // External bus cycle in flight
  input  wire logic              bus_busy_i,
  output logic                   bus_off_o,
  // Mode bit write guards
  output logic                   mode_bits_lock_o,
  // Bus keepers
  input  wire logic [15:0]       data_pin_i,
  input  wire logic              data_drv_i,
  output logic [15:0]            data_keep_o,
  output logic                   data_keep_oe_o,
  output logic                   host_keeper_en_o
);

  // ==========================================================
  // Control register
  logic [3:0] bank_compare_mask;
  logic       prog_data_read_gap;
  logic       host_port_bus_keeper;
  logic       data_bus_keeper;
  logic       ext_bus_off;
  logic       ctrl_wr;

  assign ctrl_wr = mmr_wr_i && (mmr_addr_i == `BSW_CTRL_ADDR);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      bank_compare_mask    <= `BSW_CMP_RST;
      prog_data_read_gap   <= `BSW_GAP_RST;
      host_port_bus_keeper <= `BSW_HPK_RST;
      data_bus_keeper      <= `BSW_DBK_RST;
      ext_bus_off          <= `BSW_OFF_RST;
    end
    else if (ctrl_wr)
    begin
      bank_compare_mask    <= mmr_wdata_i[`BSW_CMP_HI:`BSW_CMP_LO];
      prog_data_read_gap   <= mmr_wdata_i[`BSW_GAP_BIT];
      host_port_bus_keeper <= mmr_wdata_i[`BSW_HPK_BIT];
      data_bus_keeper      <= mmr_wdata_i[`BSW_DBK_BIT];
      ext_bus_off          <= mmr_wdata_i[`BSW_OFF_BIT];
    end
  end

  // Read data registered; reserved field reads zero
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      mmr_rdata_o <= 16'h0000;
    else if (mmr_rd_i && (mmr_addr_i == `BSW_CTRL_ADDR))
      mmr_rdata_o <= {bank_compare_mask, prog_data_read_gap, 8'h00,
                      host_port_bus_keeper, data_bus_keeper, ext_bus_off};
    else
      mmr_rdata_o <= 16'h0000;
  end

  // ==========================================================
  // Bank compare
  function automatic logic [3:0] bank_tag(input logic [ADDR_W-1:0] a, input logic [3:0] m);
    bank_tag = a[ADDR_W-1 -: 4] & m;
  endfunction

  logic [3:0] last_prog_bank;
  logic [3:0] last_data_bank;
  logic       prog_seen;
  logic       data_seen;
  logic       last_prog;
  logic       last_read;
  logic       any_seen;
  logic       need_gap;
  logic       take;
  bsw_state_t state;

  always_comb
  begin
    need_gap = 1'b0;
    if (acc_prog_i && prog_seen &&
        bank_tag(acc_addr_i, bank_compare_mask) != last_prog_bank)
      need_gap = 1'b1;
    if (!acc_prog_i && data_seen &&
        bank_tag(acc_addr_i, bank_compare_mask) != last_data_bank)
      need_gap = 1'b1;
    if (any_seen && acc_prog_i && !last_prog)
      need_gap = 1'b1;
    if (prog_data_read_gap && any_seen && acc_read_i && last_read &&
        (acc_prog_i != last_prog))
      need_gap = 1'b1;
  end

  // Access issues in IDLE without gap, or after the gap cycle
  assign take = acc_req_i && !ext_bus_off &&
                ((state == BSW_IDLE && !need_gap) || state == BSW_GAP);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state <= BSW_IDLE;
    end
    else
    begin
      unique case (state)
        BSW_IDLE:
          if (ext_bus_off)
            state <= BSW_DRAIN;
          else if (acc_req_i && need_gap)
            state <= BSW_GAP;
        BSW_GAP:
          state <= ext_bus_off ? BSW_DRAIN : BSW_IDLE;
        BSW_DRAIN:
          if (!ext_bus_off)
            state <= BSW_IDLE;
        default:
          state <= BSW_IDLE;
      endcase
    end
  end

  // History of previous access per space
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      last_prog_bank <= 4'h0;
      last_data_bank <= 4'h0;
      prog_seen      <= 1'b0;
      data_seen      <= 1'b0;
      any_seen       <= 1'b0;
      last_prog      <= 1'b0;
      last_read      <= 1'b0;
    end
    else if (take)
    begin
      any_seen  <= 1'b1;
      last_prog <= acc_prog_i;
      last_read <= acc_read_i;
      if (acc_prog_i)
      begin
        last_prog_bank <= bank_tag(acc_addr_i, bank_compare_mask);
        prog_seen      <= 1'b1;
      end
      else
      begin
        last_data_bank <= bank_tag(acc_addr_i, bank_compare_mask);
        data_seen      <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      acc_issue_o <= 1'b0;
      acc_stall_o <= 1'b0;
    end
    else
    begin
      acc_issue_o <= take;
      acc_stall_o <= acc_req_i && !take;
    end
  end

  // ==========================================================
  // Bus off: wait for the cycle in flight to finish
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      bus_off_o        <= 1'b0;
      mode_bits_lock_o <= 1'b0;
    end
    else
    begin
      bus_off_o        <= (state == BSW_DRAIN) && !bus_busy_i;
      mode_bits_lock_o <= ext_bus_off;
    end
  end

  // ==========================================================
  // Bus keepers; pin sampled twice since it is asynchronous
  logic [15:0] pin_s1;
  logic [15:0] pin_s2;
  // Drive flag delayed to line up with the synchronised pin word
  logic        drv_d1;
  logic        drv_d2;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      drv_d1 <= 1'b0;
      drv_d2 <= 1'b0;
    end
    else
    begin
      drv_d1 <= data_drv_i;
      drv_d2 <= drv_d1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pin_s1 <= 16'h0000;
      pin_s2 <= 16'h0000;
    end
    else
    begin
      pin_s1 <= data_pin_i;
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      data_keep_o      <= 16'h0000;
      data_keep_oe_o   <= 1'b0;
      host_keeper_en_o <= 1'b0;
    end
    else
    begin
      if (drv_d2)
        data_keep_o <= pin_s2;
      // Off until the last driven word is captured; off at issue since memory drives next
      data_keep_oe_o   <= data_bus_keeper && !data_drv_i && !drv_d1 && !drv_d2 &&
                          !acc_issue_o;
      host_keeper_en_o <= host_port_bus_keeper;
    end
  end

endmodule

// file: verif/bsw_asserts.sv
`include "bsw_defs.svh"
module bsw_asserts (
  input wire logic        core_clk_i, rst_i, mmr_wr_i, mmr_rd_i, acc_req_i,
  input wire logic        acc_stall_o, acc_issue_o, bus_busy_i, bus_off_o,
  input wire logic        mode_bits_lock_o, data_drv_i, data_keep_oe_o, host_keeper_en_o,
  input wire logic [15:0] mmr_addr_i, mmr_wdata_i, mmr_rdata_o, data_keep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hit;
  assign hit = mmr_addr_i == `BSW_CTRL_ADDR;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Checks
  a_rsv_zero: assert property (mmr_rd_i && hit |=> mmr_rdata_o[10:3] == 8'h00)
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property (mmr_rd_i && !hit |=> mmr_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_gap_one_cycle:
    assert property (acc_stall_o && acc_req_i && !bus_off_o && !mode_bits_lock_o |=> acc_issue_o)
    else $error("gap longer than one cycle");
  a_off_no_issue: assert property (bus_off_o && $past(bus_off_o) |-> !acc_issue_o)
    else $error("issue while bus off");
  a_off_after_idle: assert property ($rose(bus_off_o) |-> !$past(bus_busy_i))
    else $error("bus off during a cycle");
  a_lock_on_off:
    assert property (mmr_wr_i && hit && mmr_wdata_i[0] |-> ##[1:3] mode_bits_lock_o)
    else $error("mode bits not locked");
  a_keep_idle: assert property (data_keep_oe_o |-> !$past(data_drv_i))
    else $error("keeper fights a driver");
  a_keep_stable:
    assert property (data_keep_oe_o && $past(data_keep_oe_o) |-> $stable(data_keep_o))
    else $error("held value moved");
  a_host_follow:
    assert property (mmr_wr_i && hit |-> ##2 host_keeper_en_o == $past(mmr_wdata_i[2], 2))
    else $error("host keeper bit wrong");
  c_gap: cover property (acc_stall_o ##1 acc_issue_o);
  c_off: cover property ($rose(bus_off_o));
  c_keep: cover property (data_keep_oe_o);
  c_drain: cover property (mode_bits_lock_o && bus_busy_i && !bus_off_o);
endmodule
bind bsw_bank_switch bsw_asserts bsw_asserts_inst (.*);

// file: verif/bsw_ext_mem.sv
module bsw_ext_mem (
  input  wire logic clk_i, rst_i, issue_i, read_i, slow_i,
  output logic        busy_o, drv_o,
  output logic [15:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  assign busy_o = cnt != 3'h0;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= 3'h0;
    else if (issue_i)
      cnt <= slow_i ? 3'h5 : 3'h1;
    else if (busy_o)
      cnt <= cnt - 3'h1;
  end
  // ==========
  // Released bus floats: show inverse, not the old word
  always_ff @(posedge clk_i)
  begin
    drv_o <= !rst_i && (issue_i ? read_i : drv_o && cnt > 3'h1);
    if (rst_i)
      pin_o <= 16'h5AC3;
    else if (issue_i)
      pin_o <= {pin_o[14:0], pin_o[15]} ^ 16'h3B5D;
    else if (drv_o && cnt < 3'h2)
      pin_o <= ~pin_o;
  end
endmodule

// file: verif/test_bank_switch_wait_control.sv
module test_bank_switch_wait_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_i, mmr_wr_i, mmr_rd_i, acc_req_i, acc_prog_i, acc_read_i, acc_stall_o;
  logic acc_issue_o, bus_busy_i, bus_off_o, mode_bits_lock_o, data_drv_i, data_keep_oe_o;
  logic host_keeper_en_o, slow, gbit, lv, hp, hd, lp, lr;
  logic [15:0] mmr_addr_i, mmr_wdata_i, mmr_rdata_o, acc_addr_i, data_pin_i, data_keep_o, last;
  logic [31:0] seed = 32'h00010B1E;
  logic [3:0]  mask, bp, bd;
  logic [3:0]  mtab [5] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
  int          failures, n_tests, n;
  bsw_bank_switch bsw_bank_switch_inst (.*);
  bsw_ext_mem bsw_ext_mem_inst (.clk_i(core_clk_i), .rst_i, .issue_i(acc_issue_o),
    .read_i(acc_read_i), .slow_i(slow), .busy_o(bus_busy_i), .drv_o(data_drv_i),
    .pin_o(data_pin_i));
  initial
  begin
    core_clk_i = 0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (data_drv_i) last <= data_pin_i;
  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected access length from the gap rules and the bench's history
  function automatic int exp_cycles(input logic p, input logic [3:0] b, input logic r);
    return 1 + int'(lv && ((p ? hp && ((bp ^ b) & mask) != 4'h0
                              : hd && ((bd ^ b) & mask) != 4'h0)
                           || (!lp && p) || (gbit && r && lr && lp != p)));
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    mmr_addr_i = 16'h0029;
    mmr_wdata_i = d;
    mmr_wr_i = 1;
    @(posedge core_clk_i) #2 mmr_wr_i = 0;
    repeat (2) @(posedge core_clk_i) #2;
  endtask
  task automatic rd(input logic [15:0] a, exp);
    mmr_addr_i = a;
    mmr_rd_i = 1;
    @(posedge core_clk_i) #2 mmr_rd_i = 0;
    chk(mmr_rdata_o, exp);
  endtask
  // Request stays up so a following call is back to back
  task automatic acc(input logic ck, input int sp, input logic frc);
    logic [31:0] r;
    logic [3:0]  b;
    logic        p;
    int          e;
    int          s;
    r = rnd();
    p = sp < 0 ? r[0] : sp[0];
    b = r[31:28];
    acc_prog_i = p;
    acc_read_i = r[1] | frc;
    slow = r[2] | frc;
    acc_addr_i = r[31:16];
    e = exp_cycles(p, b, acc_read_i);
    s = 0;
    bp = p ? b : bp;
    bd = p ? bd : b;
    hp |= p;
    hd |= !p;
    {lv, lp, lr} = {1'b1, p, acc_read_i};
    acc_req_i = 1;
    n = 0;
    do
    begin
      @(posedge core_clk_i) #2;
      n++;
      s += int'(acc_stall_o);
    end while (!acc_issue_o && n < 20);
    if (ck) chk(16'(n), 16'(e));
    if (ck) chk(16'(s), 16'(e - 1));
  endtask
  task automatic summarize();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #200us;
    failures++;
    summarize();
  end
  // ==========
  // Main sequence
  initial
  begin
    rst_i = 1;
    {mmr_wr_i, mmr_rd_i, acc_req_i, acc_prog_i, acc_read_i, slow, lv, hp, hd, lp, lr} = '0;
    {mmr_addr_i, mmr_wdata_i, acc_addr_i} = '0;
    repeat (16) @(posedge core_clk_i);
    #2 rst_i = 0;
    rd(16'h0029, 16'hF800);
    rd(16'h0028, 16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      mask = mtab[i % 5];
      gbit = i[0];
      wr({mask, gbit, 11'h7F8});
      rd(16'h0029, {mask, gbit, 11'h000});
      acc(0, 0, 0);
      acc(0, 1, 0);
      repeat (30) acc(1, -1, 0);
      acc_req_i = 0;
    end
    wr(16'hF806);
    chk(16'(host_keeper_en_o), 16'h0001);
    acc(0, -1, 1);
    acc_req_i = 0;
    repeat (12) @(posedge core_clk_i) #2;
    chk(16'(data_keep_oe_o), 16'h0001);
    chk(data_keep_o, last);
    // Slow read still in flight when the bus is switched off
    acc(0, -1, 1);
    acc_req_i = 0;
    wr(16'hF801);
    chk(16'({bus_off_o, mode_bits_lock_o}), 16'h0001);
    repeat (6) @(posedge core_clk_i) #2;
    chk(16'({bus_off_o, mode_bits_lock_o}), 16'h0003);
    acc_req_i = 1;
    n = 0;
    repeat (6) @(posedge core_clk_i) #2 n += acc_issue_o;
    acc_req_i = 0;
    chk(16'(n), 16'h0000);
    wr(16'hF800);
    chk(16'(bus_off_o), 16'h0000);
    summarize();
  end
endmodule
